// *** hw/lfs_lock_fuse_access.sv ***
// Decided for this implementation: the address map and the APB register port.
module lfs_lock_fuse_access
  import lfs_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_CYCLES
)
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core side
  input  wire logic              spm_req,
  input  wire logic              lpm_req,
  input  wire logic [15:0]       z_addr,
  input  wire logic [7:0]        low_data_register,
  input  wire logic [7:0]        flash_rdata,
  output logic      [7:0]        lpm_data,
  output logic                   lpm_valid,
  // fuse array and eeprom status, same clock
  input  wire logic [7:0]        fuse_low_byte,
  input  wire logic [7:0]        fuse_high_byte,
  input  wire logic [2:0]        fuse_extended_byte,
  input  wire logic              eeprom_write_active,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic                 pready_r;
  logic                 pready_nxt;
  logic                 pslverr_r;
  logic                 pslverr_nxt;
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic                 enable_r;
  logic                 enable_nxt;
  logic                 select_r;
  logic                 select_nxt;
  logic                 ie_r;
  logic                 ie_nxt;
  logic [2:0]           win_r;
  logic [2:0]           win_nxt;
  logic [3:0]           pend_r;
  logic [3:0]           pend_nxt;
  logic [LOCK_W-1:0]    lock_r;
  logic [LOCK_W-1:0]    lock_nxt;
  logic [IRQ_W-1:0]     sts_r;
  logic [IRQ_W-1:0]     sts_nxt;
  logic [IRQ_W-1:0]     msk_r;
  logic [IRQ_W-1:0]     msk_nxt;
  logic [7:0]           lpm_data_r;
  logic [7:0]           lpm_data_nxt;
  logic                 lpm_valid_r;
  logic                 lpm_valid_nxt;
  logic                 irq_r;
  logic                 irq_nxt;

  logic                 prog_start;
  logic                 prog_busy;
  logic                 prog_done;
  logic                 armed;
  logic                 wr_acc;
  logic                 rd_acc;
  logic [IRQ_W-1:0]     sts_set;
  logic [IRQ_W-1:0]     sts_clr;
  logic [7:0]           sel_byte;
  logic [31:0]          ctrl_view;

  lfs_prog_timer #(
    .CYCLES (PROG_CYC)
  ) u_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (prog_start),
    .busy   (prog_busy),
    .done   (prog_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // readback byte chosen by the address pointer

  always_comb
  begin
    unique case (z_addr)
      Z_FUSE_LOW:  sel_byte = fuse_low_byte;
      Z_LOCK:      sel_byte = {UNDEF_HI2, lock_r};
      Z_FUSE_EXT:  sel_byte = {UNDEF_HI5, fuse_extended_byte};
      Z_FUSE_HIGH: sel_byte = fuse_high_byte;
      default:     sel_byte = UNMAPPED_BYTE;
    endcase
  end

  always_comb
  begin
    ctrl_view                = '0;
    ctrl_view[CTRL_EN_BIT]   = enable_r;
    ctrl_view[CTRL_SEL_BIT]  = select_r;
    ctrl_view[CTRL_IE_BIT]   = ie_r;
    ctrl_view[CTRL_BUSY_BIT] = prog_busy;
  end

  assign armed  = enable_r && select_r && !prog_busy;
  assign wr_acc = psel && penable && pready_r && pwrite;
  assign rd_acc = psel && penable && pready_r && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // sequence control

  always_comb
  begin
    enable_nxt    = enable_r;
    select_nxt    = select_r;
    ie_nxt        = ie_r;
    win_nxt       = win_r;
    pend_nxt      = pend_r;
    lock_nxt      = lock_r;
    prog_start    = 1'b0;
    sts_set       = '0;
    lpm_valid_nxt = lpm_req;
    // ordinary flash data unless the armed read path takes over
    lpm_data_nxt  = flash_rdata;

    if (armed)
    begin
      win_nxt = win_r + 3'h1;
      if (spm_req && win_r < STORE_WIN)
      begin
        if (eeprom_write_active)
        begin
          enable_nxt              = 1'b0;
          select_nxt              = 1'b0;
          sts_set[IRQ_EE_BLOCK]   = 1'b1;
        end
        else
        begin
          // pointer is not looked at here
          pend_nxt   = low_data_register[BOOT_HI:BOOT_LO];
          select_nxt = 1'b0;
          prog_start = 1'b1;
        end
      end
      else if (lpm_req && win_r < LOAD_WIN)
      begin
        enable_nxt = 1'b0;
        select_nxt = 1'b0;
        if (eeprom_write_active)
          sts_set[IRQ_EE_BLOCK] = 1'b1;
        else
        begin
          lpm_data_nxt           = sel_byte;
          sts_set[IRQ_READ_DONE] = 1'b1;
        end
      end
      else if (win_r == STORE_WIN - 3'h1)
      begin
        enable_nxt            = 1'b0;
        select_nxt            = 1'b0;
        sts_set[IRQ_TIMEOUT]  = 1'b1;
      end
    end

    // flash reads keep being served during programming; no stall path exists
    if (prog_done)
    begin
      // and-in: a zero programs, a one keeps; memory locks never touched
      lock_nxt[BOOT_HI:BOOT_LO] = lock_r[BOOT_HI:BOOT_LO] & pend_r;
      enable_nxt                = 1'b0;
      sts_set[IRQ_LOCK_DONE]    = 1'b1;
    end

    if (wr_acc && paddr == ADDR_CTRL)
    begin
      ie_nxt = pwdata[CTRL_IE_BIT];
      if (!prog_busy)
      begin
        if (pwdata[6:0] == CMD_LOCK_FUSE && !eeprom_write_active)
        begin
          enable_nxt = 1'b1;
          select_nxt = 1'b1;
          win_nxt    = '0;
        end
        else
        begin
          enable_nxt = 1'b0;
          select_nxt = 1'b0;
          if (pwdata[6:0] == CMD_LOCK_FUSE)
            sts_set[IRQ_EE_BLOCK] = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and interrupt

  always_comb
  begin
    pready_nxt  = psel && penable && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt  = '0;
    msk_nxt     = msk_r;
    sts_clr     = '0;
    if (psel && penable && !pready_r)
    begin
      unique case (paddr)
        ADDR_CTRL:    prdata_nxt = ctrl_view;
        ADDR_IRQ_STS: prdata_nxt = {{(32-IRQ_W){1'b0}}, sts_r};
        ADDR_IRQ_MSK: prdata_nxt = {{(32-IRQ_W){1'b0}}, msk_r};
        ADDR_LOCK:    prdata_nxt = {{(32-LOCK_W){1'b0}}, lock_r};
        default:      pslverr_nxt = 1'b1;
      endcase
      if (pwrite)
        prdata_nxt = '0;
    end
    if (wr_acc && paddr == ADDR_IRQ_MSK)
      msk_nxt = pwdata[IRQ_W-1:0];
    if (wr_acc && paddr == ADDR_IRQ_STS)
      sts_clr = pwdata[IRQ_W-1:0];
    // a new event outlasts a clear in the same cycle
    sts_nxt = (sts_r & ~sts_clr) | sts_set;
    irq_nxt = (|(sts_nxt & msk_nxt)) || (ie_nxt && !enable_nxt);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      prdata_r    <= '0;
      enable_r    <= 1'b0;
      select_r    <= 1'b0;
      ie_r        <= 1'b0;
      win_r       <= '0;
      pend_r      <= '0;
      lock_r      <= LOCK_RESET;
      sts_r       <= '0;
      msk_r       <= '0;
      lpm_data_r  <= '0;
      lpm_valid_r <= 1'b0;
      irq_r       <= 1'b0;
    end
    else
    begin
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      prdata_r    <= prdata_nxt;
      enable_r    <= enable_nxt;
      select_r    <= select_nxt;
      ie_r        <= ie_nxt;
      win_r       <= win_nxt;
      pend_r      <= pend_nxt;
      lock_r      <= lock_nxt;
      sts_r       <= sts_nxt;
      msk_r       <= msk_nxt;
      lpm_data_r  <= lpm_data_nxt;
      lpm_valid_r <= lpm_valid_nxt;
      irq_r       <= irq_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign lpm_data  = lpm_data_r;
  assign lpm_valid = lpm_valid_r;
  assign irq       = irq_r;

endmodule : lfs_lock_fuse_access

// *** hw/lfs_prog_timer.sv ***
module lfs_prog_timer
  import lfs_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_CYCLES
)
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [PROG_CNT_W-1:0] cnt_r;
  logic [PROG_CNT_W-1:0] cnt_nxt;
  logic                  busy_r;
  logic                  busy_nxt;
  logic                  done_r;
  logic                  done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start && !busy_r)
    begin
      cnt_nxt  = PROG_CNT_W'(CYCLES);
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      cnt_nxt = cnt_r - PROG_CNT_W'(1);
      if (cnt_r == PROG_CNT_W'(1))
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;

endmodule : lfs_prog_timer

// *** shared/lfs_pkg.sv ***
// Summary of operation
// - pattern X0001001 written, then a store within four cycles, starts a lock write
// - a lock write reaches only the four boot lock bits
// - data bits 5:2 cleared to zero program the matching boot lock bit
// - flash stays readable and fetches never stall while lock bits program
// - an active data-EEPROM write blocks every self-programming operation
// - an active data-EEPROM write blocks fuse and lock readback
// - pointer 0x0001, armed, load within three cycles returns the lock bits
// - select and enable clear on read done, load timeout or store timeout
// - with select and enable clear, loads return ordinary flash contents
// - lock readback: bits 7:6 undefined, 5:2 boot locks, 1:0 memory locks
// - pointer 0x0000, armed, load within three cycles returns fuse low byte
// - pointer 0x0003, armed, load within three cycles returns fuse high byte
// - pointer 0x0002 returns extended fuse byte; only bits 2:0 defined
// - returned fuse and lock bits read 0 programmed, 1 unprogrammed
// - with interrupt enabled, interrupt stays asserted while enable bit is clear
package lfs_pkg;

  localparam int          APB_AW         = 8;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_IRQ_STS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_MSK   = 8'h08;
  localparam logic [7:0]  ADDR_LOCK      = 8'h0c;

  // control_status layout
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_SEL_BIT   = 3;
  localparam int          CTRL_IE_BIT    = 7;
  localparam int          CTRL_BUSY_BIT  = 8;
  localparam logic [6:0]  CMD_LOCK_FUSE  = 7'h09;

  // sequence windows in cycles after the control write
  localparam logic [2:0]  LOAD_WIN       = 3'h3;
  localparam logic [2:0]  STORE_WIN      = 3'h4;

  localparam logic [15:0] Z_FUSE_LOW     = 16'h0000;
  localparam logic [15:0] Z_LOCK         = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT     = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH    = 16'h0003;

  localparam int          LOCK_W         = 6;
  localparam int          BOOT_LO        = 2;
  localparam int          BOOT_HI        = 5;
  localparam logic [5:0]  LOCK_RESET     = 6'h3f;
  localparam logic [1:0]  UNDEF_HI2      = 2'h3;
  localparam logic [4:0]  UNDEF_HI5      = 5'h1f;
  localparam logic [7:0]  UNMAPPED_BYTE  = 8'hff;

  // irq status / mask layout
  localparam int          IRQ_W          = 4;
  localparam int          IRQ_LOCK_DONE  = 0;
  localparam int          IRQ_READ_DONE  = 1;
  localparam int          IRQ_TIMEOUT    = 2;
  localparam int          IRQ_EE_BLOCK   = 3;

  localparam int          CLK_MHZ        = 200;
  localparam int          PROG_TIME_US   = 3700;
  localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
  localparam int          PROG_CNT_W     = 20;

endpackage : lfs_pkg

// *** tb/lfs_core_model.sv ***
module lfs_core_model
  import lfs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [7:0]  lpm_data,
  output logic             spm_req,
  output logic             lpm_req,
  output logic [15:0]      z_addr,
  output logic [7:0]       low_data_register,
  output logic [7:0]       flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // flash content is a fixed pattern of the pointer
  assign flash_rdata = z_addr[7:0] ^ 8'h5a;
  initial
  begin
    spm_req = 1'b0;
    lpm_req = 1'b0;
    z_addr = Z_LOCK;
    low_data_register = 8'h00;
  end
  task automatic load(input logic [15:0] z, input int d, output logic [7:0] q);
    z_addr <= z;
    repeat (d - 1) @(posedge clock);
    lpm_req <= 1'b1;
    @(posedge clock);
    lpm_req <= 1'b0;
    z_addr <= ~z;
    // answer stands for the cycle after the request edge
    @(negedge clock);
    q = lpm_data;
  endtask : load
  task automatic store(input logic [7:0] dat, input int d);
    z_addr <= Z_LOCK;
    low_data_register <= dat | 8'hc3;
    repeat (d - 1) @(posedge clock);
    spm_req <= 1'b1;
    @(posedge clock);
    spm_req <= 1'b0;
    low_data_register <= ~(dat | 8'hc3);
  endtask : store
endmodule : lfs_core_model

// *** tb/lfs_lock_fuse_access_assertions.sv ***
module lfs_lock_fuse_access_assertions
  import lfs_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        lpm_req,
  input wire logic [15:0] z_addr,
  input wire logic [7:0]  flash_rdata,
  input wire logic [7:0]  lpm_data,
  input wire logic        lpm_valid,
  input wire logic        eeprom_write_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_load;
    lpm_req;
  endsequence
  sequence s_answer(logic [15:0] z);
    lpm_valid && $past(z_addr) == z && lpm_data != $past(flash_rdata);
  endsequence
  a_apb_one_wait: assert property (s_access |=> pready)
    else $error("apb answer not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_load_answer: assert property (s_load |=> lpm_valid)
    else $error("load not answered next cycle");
  a_no_spur_valid: assert property (!lpm_req |=> !lpm_valid)
    else $error("lpm_valid without load");
  a_ee_block_read: assert property (s_load ##0 eeprom_write_active |=> lpm_data == $past(flash_rdata))
    else $error("fuse read not blocked by eeprom write");
  a_ext_format: assert property (s_answer(Z_FUSE_EXT) |-> lpm_data[7:3] == UNDEF_HI5)
    else $error("extended fuse upper bits wrong");
  a_lock_format: assert property (s_answer(Z_LOCK) |-> lpm_data[7:6] == UNDEF_HI2)
    else $error("lock byte upper bits wrong");
endmodule : lfs_lock_fuse_access_assertions

bind lfs_lock_fuse_access lfs_lock_fuse_access_assertions chk_inst (.clock(clock),
  .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .lpm_req(lpm_req), .z_addr(z_addr), .flash_rdata(flash_rdata),
  .lpm_data(lpm_data), .lpm_valid(lpm_valid), .eeprom_write_active(eeprom_write_active));

// *** tb/lfs_lock_fuse_access_tb_top.sv ***
module lfs_lock_fuse_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lfs_pkg::*;
  localparam int unsigned PC = 20;
  logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ee = 1'b0, err, pready, pslverr;
  logic        spm_req, lpm_req, lpm_valid, irq;
  logic [7:0]  paddr = 8'h00, fl = 8'h00, fh = 8'h00, ldr, frd, lpm_data, q, dat;
  logic [2:0]  fe = 3'h0;
  logic [5:0]  lock;
  logic [15:0] z_addr;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hb2ba;
  int          fails = 0, checks_done = 0, cyc = 0;
  always #2.5 clock = ~clock;
  lfs_lock_fuse_access #(.PROG_CYC(PC)) lfs_lock_fuse_access_inst (.clock(clock),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spm_req(spm_req), .lpm_req(lpm_req), .z_addr(z_addr), .low_data_register(ldr),
    .flash_rdata(frd), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
    .fuse_low_byte(fl), .fuse_high_byte(fh), .fuse_extended_byte(fe),
    .eeprom_write_active(ee), .irq(irq));
  lfs_core_model core (.clock(clock), .lpm_data(lpm_data), .spm_req(spm_req),
    .lpm_req(lpm_req), .z_addr(z_addr), .low_data_register(ldr), .flash_rdata(frd));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_rd(input logic [15:0] z);
    case (z)
      Z_FUSE_LOW:  return fl;
      Z_LOCK:      return {UNDEF_HI2, lock};
      Z_FUSE_EXT:  return {UNDEF_HI5, fe};
      Z_FUSE_HIGH: return fh;
      default:     return UNMAPPED_BYTE;
    endcase
  endfunction : exp_rd
  task automatic final_report;
    if (fails == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // look mid-cycle, where the answer has settled; it stands through the next edge
    do @(negedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
  endtask : rdchk
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clock);
    chk("irq", e, irq);
  endtask : irqchk
  // hang guard, run needs a few hundred cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    lock = LOCK_RESET;
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_LOCK, 32'h3f);
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 1, err);
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      dat = (i == 0) ? 8'hff : seed[7:0];
      apb(1'b1, ADDR_CTRL, 32'h09);
      core.store(dat, 1 + seed[9:8]);
      core.load(16'h0100, 1, q);
      chk("busy load", 8'h5a, q);
      lock = lock & {dat[5:2], 2'b11};
      do apb(1'b0, ADDR_CTRL, 32'h0); while (rd[CTRL_BUSY_BIT] !== 1'b0);
      rdchk(ADDR_LOCK, lock);
      apb(1'b1, ADDR_IRQ_STS, 32'hf);
    end
    apb(1'b1, ADDR_IRQ_MSK, 32'hf);
    for (int i = 0; i < 10; i++)
    begin
      seed = lfsr(seed);
      {fl, fh, fe} <= seed[18:0];
      apb(1'b1, ADDR_CTRL, 32'h09);
      core.load(i % 5, 1 + seed[21:20] % 3, q);
      chk("readback", exp_rd(i % 5), q);
      rdchk(ADDR_CTRL, 32'h0);
      irqchk(1'b1);
      apb(1'b1, ADDR_IRQ_STS, 32'hf);
    end
    // masked timeout, then unmask and clear
    apb(1'b1, ADDR_IRQ_MSK, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h09);
    core.load(Z_FUSE_LOW, 4, q);
    chk("late load", 8'h5a, q);
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_IRQ_STS, 32'h4);
    irqchk(1'b0);
    apb(1'b1, ADDR_IRQ_MSK, 32'hf);
    irqchk(1'b1);
    apb(1'b1, ADDR_IRQ_STS, 32'h4);
    irqchk(1'b0);
    ee <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h09);
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_IRQ_STS, 32'h8);
    ee <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h09);
    ee <= 1'b1;
    core.load(Z_FUSE_LOW, 1, q);
    chk("ee load", 8'h5a, q);
    ee <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h09);
    ee <= 1'b1;
    core.store(8'h00, 1);
    ee <= 1'b0;
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_LOCK, lock);
    apb(1'b1, ADDR_IRQ_STS, 32'hf);
    apb(1'b1, ADDR_CTRL, 32'h80);
    irqchk(1'b1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    irqchk(1'b0);
    final_report();
  end
endmodule : lfs_lock_fuse_access_tb_top
